// >>> design/dgf_consts.vh
// Constants of the DMA group sample framer: register map, fields, codes.
// Assumes a 10-bit byte address with 32-bit aligned registers.
// Operation
// R1 - Channel-count descriptor, one 16-bit entry per group
// R2 - Frame-format descriptor: 0 format A, 1 format B
// R3 - Bytes-per-sample descriptor: 1,2,4,8; 0 invalid
// R4 - One sample width for all channels of a group
// R5 - Block-length descriptor in 64-bit words per group
// R6 - Each group feeds its own 64-bit FIFO
// R7 - At most sixteen groups, indices zero to fifteen
// R8 - Host-written 16-bit sampling-rate control per group
// R9 - Overflow word, one bit per group, 1 overflowed
// R10 - Group acquires only while its enable is true
// R11 - Simulation replaces samples with ramp up to block length
// R12 - Debug control register selects simulated data path
// R13 - Format A groups carry 1 to 32 channels
// R14 - Block length multiple of channels times width over four
// R15 - Samples packed into complete 64-bit words
// R16 - Digital lines acquired as byte-wide channels of eight
// R17 - Analog bundle: one to four 16-bit channels packed
// R18 - Format B reserved, carries no acquisition yet
// R19 - One run control starts and stops all groups
// R20 - Channels interleaved from least significant byte upward
// R21 - Overflow sets on write into full FIFO, held till restart
`ifndef DGF_CONSTS_VH
`define DGF_CONSTS_VH

// Register regions, 16 words each, indexed by group
`define DGF_OFS_CHAN_COUNTS 10'h000
`define DGF_OFS_FRAME_FORMATS 10'h040
`define DGF_OFS_SAMPLE_WIDTHS 10'h080
`define DGF_OFS_BLOCK_LENGTHS 10'h0c0
`define DGF_OFS_SAMPLING_RATE 10'h100
`define DGF_OFS_ACQUIRE_ENABLE 10'h140
// Single registers
`define DGF_OFS_OVERFLOW_FLAGS 10'h180
`define DGF_OFS_CONTROL 10'h184
`define DGF_OFS_GROUP_TOTAL 10'h188

// Control register fields
`define DGF_CTRL_RUN_BIT 0
`define DGF_CTRL_SIM_BIT 1

// Frame format codes
`define DGF_FMT_A 8'h00
`define DGF_FMT_B 8'h01

// Upper bounds
`define DGF_MAX_GROUPS 16
`define DGF_MAX_CHANS 16'h0020

// Reset values
`define DGF_RATE_RESET 16'h0000
`define DGF_ENABLE_RESET 1'b0
`define DGF_CTRL_RESET 2'b00

`endif

// >>> design/dgf_packer.v
// One group's packer: walks the channels, packs samples into 64-bit words.
// Assumes sample data for the channel on src_chan arrive from same-clock logic.
`timescale 1ns/1ps
`include "dgf_consts.vh"

module dgf_packer (
	input wire core_clk,
	input wire arst_n,
	input wire tick,
	input wire active,
	input wire restart,
	input wire sim,
	input wire [15:0] chan_count,
	input wire [7:0] sample_width,
	input wire [15:0] block_words,
	input wire [63:0] src_data,
	input wire fifo_ready,
	output reg [4:0] src_chan,
	output reg [63:0] fifo_data,
	output reg fifo_wr,
	output reg overflow
);
	// One-hot states
	localparam ST_IDLE = 2'b01;
	localparam ST_SWEEP = 2'b10;

	// Width code to byte count; illegal codes give zero
	function [3:0] width_bytes;
		input [7:0] code;
		begin
			case (code)
				8'h01: width_bytes = 4'h1;
				8'h02: width_bytes = 4'h2;
				8'h04: width_bytes = 4'h4;
				8'h08: width_bytes = 4'h8;
				default: width_bytes = 4'h0;
			endcase
		end
	endfunction

	reg [1:0] state; // Sweep state
	reg [2:0] ptr; // Next free byte lane
	reg [63:0] acc; // Partly filled word
	reg [15:0] ramp; // Test ramp value
	wire [3:0] wbytes; // Bytes per sample
	wire [63:0] mask; // Keeps only W bytes
	wire [63:0] sample; // Live or simulated sample
	wire [63:0] placed; // Sample moved to its lane
	wire [3:0] lane_sum; // Lane after this sample
	wire word_done; // Word is complete
	wire last_chan; // Final channel of sweep
	wire [5:0] chan_next; // Channel plus one

	assign wbytes = width_bytes(sample_width);
	// Mask from byte count; a whole word for eight bytes
	assign mask = (wbytes == 4'h8) ? 64'hffffffffffffffff :
		((64'h1 << {wbytes[2:0], 3'b000}) - 64'h1);
	// Debug path swaps the live sample for the ramp [R11] [R12]
	assign sample = (sim ? {48'h0, ramp} : src_data) & mask;
	// Lowest byte lane first, channels in ascending order [R20] [R16] [R17]
	assign placed = sample << {ptr, 3'b000};
	assign lane_sum = {1'b0, ptr} + wbytes;
	// Same W for every channel keeps lanes aligned [R4]
	assign word_done = lane_sum[3];
	assign chan_next = {1'b0, src_chan} + 6'h01;
	// A zero count is treated as one channel
	assign last_chan = ({10'h000, chan_next} >= chan_count);

	// Sweep, packing and FIFO write
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= ST_IDLE;
			ptr <= 3'h0;
			acc <= 64'h0;
			src_chan <= 5'h00;
			fifo_data <= 64'h0;
			fifo_wr <= 1'b0;
			ramp <= 16'h0000;
		end
		else if (!active)
		begin
			// Stopped: drop any partial word so restart is clean [R10]
			state <= ST_IDLE;
			ptr <= 3'h0;
			acc <= 64'h0;
			src_chan <= 5'h00;
			fifo_wr <= 1'b0;
			ramp <= 16'h0000;
		end
		else
		begin
			fifo_wr <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					// A sampling tick starts one sweep of all channels
					if (tick)
					begin
						state <= ST_SWEEP;
						src_chan <= 5'h00;
					end
				end
				ST_SWEEP:
				begin
					// One channel per cycle; ticks during a sweep are lost
					if (word_done)
					begin
						// Only complete words reach the FIFO [R15] [R6]
						fifo_data <= acc | placed;
						fifo_wr <= fifo_ready; // [R21]
						acc <= 64'h0;
						ptr <= 3'h0;
					end
					else
					begin
						acc <= acc | placed;
						ptr <= lane_sum[2:0];
					end
					// Ramp peaks at the block length, then wraps [R11]
					if (ramp >= block_words)
						ramp <= 16'h0000;
					else
						ramp <= ramp + 16'h0001;
					if (last_chan)
					begin
						state <= ST_IDLE;
						src_chan <= 5'h00;
					end
					else
						src_chan <= chan_next[4:0];
				end
				default:
				begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Sticky overflow; a lost word wins over the restart clear [R21] [R9]
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			overflow <= 1'b0;
		else if (active && state == ST_SWEEP && word_done && !fifo_ready)
			overflow <= 1'b1;
		else if (restart)
			overflow <= 1'b0;
	end
endmodule

// >>> design/dgf_framer.v
// Top of the DMA group sample framer: register port, rate dividers, packers.
// Assumes one clock, a single-cycle strobe register master and per-group
// target-to-host FIFOs whose ready means "not full".
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "dgf_consts.vh"

module dgf_framer #(
	parameter NUM_GROUPS = 16,
	// Per-group descriptors, group 0 in the low slice
	parameter [255:0] CHAN_COUNTS = {16{16'h0001}},
	parameter [127:0] FRAME_FORMATS = {16{8'h00}},
	parameter [127:0] SAMPLE_WIDTHS = {16{8'h02}},
	parameter [255:0] BLOCK_WORDS = {16{16'h0400}}
) (
	input wire core_clk,
	input wire arst_n,
	input wire [9:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire [64*NUM_GROUPS-1:0] src_data,
	output wire [5*NUM_GROUPS-1:0] src_chan,
	output wire [64*NUM_GROUPS-1:0] fifo_data,
	output wire [NUM_GROUPS-1:0] fifo_wr,
	input wire [NUM_GROUPS-1:0] fifo_ready
);
	// Group count fits the sixteen FIFO channels [R7]
	localparam NG = (NUM_GROUPS > `DGF_MAX_GROUPS) ? `DGF_MAX_GROUPS : NUM_GROUPS;
	// Control reset word, split into its run and debug bits
	localparam [1:0] CTRL_RST = `DGF_CTRL_RESET;

	// Address region field (64-byte regions)
	function [3:0] addr_region;
		input [9:0] addr;
		begin
			addr_region = addr[9:6];
		end
	endfunction

	// Group index within a region
	function [3:0] addr_index;
		input [9:0] addr;
		begin
			addr_index = addr[5:2];
		end
	endfunction

	reg [15:0] rate [0:15]; // Sampling rate controls
	reg [15:0] enable; // Group enables
	reg run; // Common start/stop
	reg sim; // Simulated data select
	reg run_q; // Run one cycle ago
	wire restart; // Run rising edge
	wire [15:0] ovf; // Per-group overflow
	wire [3:0] wr_region; // Decoded write region
	wire [3:0] wr_index; // Decoded write index
	wire [3:0] rd_region; // Decoded read region
	wire [3:0] rd_index; // Decoded read index
	reg [31:0] next_rdata; // Read mux result
	integer i;

	assign wr_region = addr_region(reg_addr);
	assign wr_index = addr_index(reg_addr);
	assign rd_region = addr_region(reg_addr);
	assign rd_index = addr_index(reg_addr);
	// Overflows of a fresh run are wiped on its first cycle
	assign restart = run & ~run_q;

	// Writable registers; rates and enables apply the next cycle
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (i = 0; i < 16; i = i + 1)
				rate[i] <= `DGF_RATE_RESET;
			enable <= {16{`DGF_ENABLE_RESET}};
			run <= CTRL_RST[`DGF_CTRL_RUN_BIT];
			sim <= CTRL_RST[`DGF_CTRL_SIM_BIT];
		end
		else if (reg_wr)
		begin
			if (wr_region == addr_region(`DGF_OFS_SAMPLING_RATE))
			begin
				// Host sets each group's rate [R8]
				if ({28'h0, wr_index} < NG)
					rate[wr_index] <= reg_wdata[15:0];
			end
			else if (wr_region == addr_region(`DGF_OFS_ACQUIRE_ENABLE))
			begin
				// Per-group enable, bit 0 of the word [R10]
				if ({28'h0, wr_index} < NG)
					enable[wr_index] <= reg_wdata[0];
			end
			else if (reg_addr == `DGF_OFS_CONTROL)
			begin
				// One run bit for every group [R19]; debug select [R12]
				run <= reg_wdata[`DGF_CTRL_RUN_BIT];
				sim <= reg_wdata[`DGF_CTRL_SIM_BIT];
			end
		end
	end

	// Edge detector for the run bit
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			run_q <= 1'b0;
		else
			run_q <= run;
	end

	// Per-group rate divider and packer
	genvar g;
	generate
		for (g = 0; g < NG; g = g + 1)
		begin : grp
			reg [15:0] div_cnt; // Cycles since last tick
			wire legal; // Descriptor usable
			wire active; // Group acquiring
			wire tick; // Sampling instant
			wire [15:0] cnt_d; // Channel count
			wire [7:0] fmt_d; // Frame format
			wire [7:0] wid_d; // Sample width

			assign cnt_d = CHAN_COUNTS[16*g +: 16];
			assign fmt_d = FRAME_FORMATS[8*g +: 8];
			assign wid_d = SAMPLE_WIDTHS[8*g +: 8];
			// Only format A with 1..32 channels and a legal W runs;
			// format B stays silent until it is defined [R13] [R18] [R3]
			assign legal = (fmt_d == `DGF_FMT_A) && (cnt_d != 16'h0000) &&
				(cnt_d <= `DGF_MAX_CHANS) &&
				(wid_d == 8'h01 || wid_d == 8'h02 || wid_d == 8'h04 || wid_d == 8'h08);
			assign active = run & enable[g] & legal; // [R10] [R19]
			// Rate value N gives one sweep every N+1 clocks while N is at least the channel count
			assign tick = active && (div_cnt >= rate[g]);

			// Divider, held at zero while the group is stopped
			always @(posedge core_clk or negedge arst_n)
			begin
				if (!arst_n)
					div_cnt <= 16'h0000;
				else if (!active || tick)
					div_cnt <= 16'h0000;
				else
					div_cnt <= div_cnt + 16'h0001;
			end

			dgf_packer u_packer (
				.core_clk(core_clk),
				.arst_n(arst_n),
				.tick(tick),
				.active(active),
				.restart(restart),
				.sim(sim),
				.chan_count(cnt_d),
				.sample_width(wid_d),
				.block_words(BLOCK_WORDS[16*g +: 16]),
				.src_data(src_data[64*g +: 64]),
				.fifo_ready(fifo_ready[g]),
				.src_chan(src_chan[5*g +: 5]),
				.fifo_data(fifo_data[64*g +: 64]),
				.fifo_wr(fifo_wr[g]),
				.overflow(ovf[g])
			);
		end
		// Unbuilt groups never overflow
		for (g = NG; g < 16; g = g + 1)
		begin : nogrp
			assign ovf[g] = 1'b0;
		end
	endgenerate

	// Read mux; descriptors are constants, block lengths trust the
	// integer-multiple relation chosen at build time [R14]
	always @*
	begin
		next_rdata = 32'h00000000;
		case (rd_region)
			4'h0:
				if ({28'h0, rd_index} < NG)
					next_rdata = {16'h0000, CHAN_COUNTS[16*rd_index +: 16]}; // [R1]
			4'h1:
				if ({28'h0, rd_index} < NG)
					next_rdata = {24'h000000, FRAME_FORMATS[8*rd_index +: 8]}; // [R2]
			4'h2:
				if ({28'h0, rd_index} < NG)
					next_rdata = {24'h000000, SAMPLE_WIDTHS[8*rd_index +: 8]}; // [R3]
			4'h3:
				if ({28'h0, rd_index} < NG)
					next_rdata = {16'h0000, BLOCK_WORDS[16*rd_index +: 16]}; // [R5]
			4'h4:
				next_rdata = {16'h0000, rate[rd_index]};
			4'h5:
				next_rdata = {31'h00000000, enable[rd_index]};
			4'h6:
			begin
				// Single registers of the last region
				if (reg_addr == `DGF_OFS_OVERFLOW_FLAGS)
					next_rdata = {16'h0000, ovf}; // [R9]
				else if (reg_addr == `DGF_OFS_CONTROL)
					next_rdata = {30'h00000000, sim, run};
				else if (reg_addr == `DGF_OFS_GROUP_TOTAL)
					next_rdata = NG; // Array length for the host [R1]
			end
			default:
				next_rdata = 32'h00000000;
		endcase
	end

	// Read data stand in the cycle after the strobe only
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= 32'h00000000;
	end
endmodule

// >>> tb/dgf_framer_chk.sv
// Port-level checker for the DMA group sample framer.
// Assumes group 0 is a format A group and group 1 may be format B.
`timescale 1ns/1ps
module dgf_framer_chk #(
	parameter NUM_GROUPS = 16,
	parameter [255:0] CHAN_COUNTS = {16{16'h0001}},
	parameter [127:0] FRAME_FORMATS = {16{8'h00}}
) (
	input wire core_clk,
	input wire arst_n,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire [5*NUM_GROUPS-1:0] src_chan,
	input wire [NUM_GROUPS-1:0] fifo_wr,
	input wire [NUM_GROUPS-1:0] fifo_ready
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// One sweep of a two-channel group: channel 0 then channel 1
	sequence s_sweep;
		src_chan[4:0] == 5'h00 ##1 src_chan[4:0] == 5'h01;
	endsequence
	a_rdata_only_after: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	a_wr_one_cycle: assert property (fifo_wr[0] |=> !fifo_wr[0])
		else $error("fifo write longer than one cycle");
	a_chan_in_range: assert property ({11'h000, src_chan[4:0]} < CHAN_COUNTS[15:0])
		else $error("channel index beyond count");
	a_fmt_b_quiet: assert property (FRAME_FORMATS[15:8] == 8'h01 |-> !fifo_wr[1])
		else $error("format B group wrote");
	a_wr_needs_ready: assert property (fifo_wr[0] |-> $past(fifo_ready[0]))
		else $error("write into full fifo");
	a_word_after_last: assert property (fifo_wr[0] |-> $past(src_chan[4:0]) == 5'h01)
		else $error("word not closed by last channel");
	a_sweep_order: assert property (src_chan[4:0] == 5'h01 |-> $past(src_chan[4:0]) == 5'h00)
		else $error("channels out of order");
	// A register write two cycles back may have stopped the group mid-sweep
	a_sweep_word: assert property (s_sweep ##1 ($past(fifo_ready[0]) && !$past(reg_wr, 2))
		|-> fifo_wr[0])
		else $error("full sweep gave no word");
endmodule
bind dgf_framer dgf_framer_chk #(.NUM_GROUPS(NUM_GROUPS), .CHAN_COUNTS(CHAN_COUNTS),
	.FRAME_FORMATS(FRAME_FORMATS)) u_chk (.core_clk(core_clk), .arst_n(arst_n),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_chan(src_chan),
	.fifo_wr(fifo_wr),
	.fifo_ready(fifo_ready));

// >>> tb/dgf_host_model.sv
// Host side of one group: a FIFO that collects words and can stall.
// Assumes the framer writes one word per fifo_wr pulse.
`timescale 1ns/1ps
module dgf_host_model (
	input wire core_clk,
	input wire stall,
	input wire fifo_wr,
	input wire [63:0] fifo_data,
	output wire fifo_ready
);
	// Collected words; unbounded so only the stall input makes it full
	logic [63:0] words[$];
	// Full while stalled, so overflow can be provoked on demand
	assign fifo_ready = !stall;
	// Accept a whole 64-bit word per write
	always @(posedge core_clk)
		if (fifo_wr && fifo_ready)
			words.push_back(fifo_data);
endmodule

// >>> tb/dgf_framer_tb.sv
// Testbench of the DMA group sample framer: register tasks and host models.
// Assumes two groups: 0 is format A with two 4-byte channels, 1 is format B.
`timescale 1ns/1ps
module dgf_framer_tb;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [9:0] reg_addr = 10'h000;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] stall = 2'b00;
	wire [31:0] reg_rdata;
	wire [127:0] src_data;
	wire [9:0] src_chan;
	wire [127:0] fifo_data;
	wire [1:0] fifo_wr;
	wire [1:0] fifo_ready;
	int fails = 0;
	int num_checks = 0;
	int cycles = 0;
	int base;
	logic [63:0] w;
	// Channel number visible in every sample of group 0
	assign src_data = {64'h0f0f_0f0f_0f0f_0f0f, 32'h0, 16'hc0de, 11'h0, src_chan[4:0]};
	dgf_framer #(.NUM_GROUPS(2), .CHAN_COUNTS({224'h0, 16'h0001, 16'h0002}),
		.FRAME_FORMATS({112'h0, 8'h01, 8'h00}), .SAMPLE_WIDTHS({112'h0, 8'h08, 8'h04}),
		.BLOCK_WORDS({224'h0, 16'h0008, 16'h0004})) u_dut (.core_clk(core_clk),
		.arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_data(src_data), .src_chan(src_chan),
		.fifo_data(fifo_data), .fifo_wr(fifo_wr), .fifo_ready(fifo_ready));
	dgf_host_model u_host0 (.core_clk(core_clk), .stall(stall[0]), .fifo_wr(fifo_wr[0]),
		.fifo_data(fifo_data[63:0]), .fifo_ready(fifo_ready[0]));
	dgf_host_model u_host1 (.core_clk(core_clk), .stall(stall[1]), .fifo_wr(fifo_wr[1]),
		.fifo_data(fifo_data[127:64]), .fifo_ready(fifo_ready[1]));
	// 100 ns clock
	always #50 core_clk = ~core_clk;
	// Hang guard
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			wrap_up();
		end
	end
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic reg_write(input logic [9:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic reg_read(input logic [9:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		// Taken at the edge that closes the data cycle, before it clears
		@(posedge core_clk);
		d = reg_rdata;
	endtask
	task automatic read_check(input string name, input logic [9:0] a, input logic [31:0] e);
		logic [31:0] v;
		reg_read(a, v);
		check(name, {32'h0, v}, {32'h0, e});
	endtask
	// Bounded wait for group 0 to reach a word count
	task automatic wait_words(input int n);
		int k;
		for (k = 0; k < 500 && u_host0.words.size() < n; k++)
			@(posedge core_clk);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		read_check("nch0", 10'h000, 32'h2);
		read_check("nch1", 10'h004, 32'h1);
		read_check("nch_beyond", 10'h008, 32'h0);
		read_check("fmt1", 10'h044, 32'h1);
		read_check("width0", 10'h080, 32'h4);
		read_check("width1", 10'h084, 32'h8);
		read_check("blk0", 10'h0c0, 32'h4);
		read_check("unmapped", 10'h3fc, 32'h0);
		read_check("groups", 10'h188, 32'h2);
		read_check("rate_reset", 10'h100, 32'h0);
		reg_write(10'h104, 32'hffff_ffff);
		read_check("rate1", 10'h104, 32'hffff);
		reg_write(10'h100, 32'h3);
		reg_write(10'h140, 32'h1);
		reg_write(10'h144, 32'h1);
		read_check("enable0", 10'h140, 32'h1);
		reg_write(10'h184, 32'h1);
		read_check("ctrl_run", 10'h184, 32'h1);
		wait_words(3);
		w = u_host0.words[0];
		check("word0", w, 64'hc0de_0001_c0de_0000);
		check("word2", u_host0.words[2], 64'hc0de_0001_c0de_0000);
		check("fmt_b_words", u_host1.words.size(), 64'h0);
		read_check("ovf_clear", 10'h180, 32'h0);
		@(posedge core_clk);
		stall <= 2'b01;
		repeat (30) @(posedge core_clk);
		stall <= 2'b00;
		read_check("ovf_set", 10'h180, 32'h1);
		repeat (10) @(posedge core_clk);
		read_check("ovf_held", 10'h180, 32'h1);
		reg_write(10'h184, 32'h0);
		reg_write(10'h184, 32'h3);
		read_check("ovf_restart", 10'h180, 32'h0);
		base = u_host0.words.size();
		wait_words(base + 2);
		w = u_host0.words[base + 1];
		check("ramp_top", {63'h0, w[31:0] <= 32'h4}, 64'h1);
		check("ramp_step", w[63:32], (w[31:0] == 32'h4) ? 64'h0 : w[31:0] + 1);
		reg_write(10'h140, 32'h0);
		repeat (4) @(posedge core_clk);
		base = u_host0.words.size();
		repeat (40) @(posedge core_clk);
		check("stopped", u_host0.words.size(), base);
		wrap_up();
	end
endmodule
